//--- rbc_cfg.svh
`ifndef RBC_CFG_SVH
`define RBC_CFG_SVH

// Register byte offsets
`define RBC_A_TIME 8'h00
`define RBC_A_DATE 8'h04
`define RBC_A_CTRL 8'h08
`define RBC_A_PRESC 8'h0c
`define RBC_A_WAKE 8'h10
`define RBC_A_ALM_A 8'h14
`define RBC_A_ALM_B 8'h18
`define RBC_A_ALM_A_SS 8'h1c
`define RBC_A_ALM_B_SS 8'h20
`define RBC_A_SUBSEC 8'h24
`define RBC_A_STATUS 8'h28
`define RBC_A_MASK 8'h2c
`define RBC_A_TSTAMP 8'h30
`define RBC_A_BKP_BASE 8'h40
`define RBC_A_BKP_END 8'h90
`define RBC_BKP_WORDS 20

// Control field positions
`define RBC_C_FMT12 0
`define RBC_C_ALM_A_EN 1
`define RBC_C_ALM_B_EN 2
`define RBC_C_WAKE_EN 3
`define RBC_C_REF_EN 4
`define RBC_C_REF_60 5
`define RBC_C_CAL_EN 6
`define RBC_C_SRC_LO 8
`define RBC_C_SRC_HI 9
`define RBC_C_WSEL_LO 10
`define RBC_C_WSEL_HI 12
`define RBC_CTRL_W 13

// Status bit positions
`define RBC_S_ALM_A 0
`define RBC_S_ALM_B 1
`define RBC_S_WAKE 2
`define RBC_S_TAMPER 3
`define RBC_S_TSTAMP 4
`define RBC_STAT_W 5

// Reset values
`define RBC_CTRL_RST 13'h0000
`define RBC_PRESC_A_RST 7'h7f
`define RBC_PRESC_S_RST 13'h00ff
`define RBC_WAKE_RST 16'hffff
`define RBC_DATE_RST 32'h0000_2101

// Timing counts
`define RBC_HSE_DIV_TC 7'h7f
`define RBC_REF50_TC 6'h31
`define RBC_REF60_TC 6'h3b

`endif

//--- rbc_pkg.sv
package rbc_pkg;

  // Counting clock source
  typedef enum logic [1:0] {
    RBC_SRC_LSE = 2'h0,
    RBC_SRC_LSI = 2'h1,
    RBC_SRC_HSE = 2'h2,
    RBC_SRC_OFF = 2'h3
  } rbc_clk_src_e;

  typedef logic [31:0] rbc_word_t;

endpackage : rbc_pkg

//--- rbc_backup_mem.sv
`include "rbc_cfg.svh"

module rbc_backup_mem (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic rd_sel_i,
  input wire logic [4:0] rd_idx_i,
  input wire logic [31:0] bypass_i,
  output logic [31:0] rd_data_o
);

  logic [31:0] mem [0:`RBC_BKP_WORDS-1];

  // Array has no reset, so words survive every reset
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // Read register, shared with the register file answer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_o <= 32'h0;
    end else if (rd_en_i) begin
      rd_data_o <= rd_sel_i ? mem[rd_idx_i] : bypass_i;
    end else begin
      rd_data_o <= 32'h0;
    end
  end

endmodule : rbc_backup_mem

//--- rbc_top.sv
// Contract
// - BCD calendar fields, 12 or 24 hour
// - Month length and leap February handled
// - Mains reference may drive the seconds
// - Alarm and periodic events wake chip
// - Sub-second count readable in binary
// - Clock from LSE, LSI or HSE/128
// - Optional 512 Hz calibration output
// - Two alarms with per-field masks
// - 16-bit auto-reload wakeup downcounter
// - 20-bit prescaler, one second default
// - Twenty 32-bit backup words
// - Backup words untouched by any reset
// - Alarm words hold sub-second to date
// - Events drive external interrupt lines
// - Events request exit from Standby
// - No wakeup while on battery supply
`include "rbc_cfg.svh"

module rbc_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic lse_clk_i,
  input wire logic lsi_clk_i,
  input wire logic hse_clk_i,
  input wire logic ref_clk_i,
  input wire logic tamper_i,
  input wire logic tstamp_i,
  input wire logic battery_mode_i,
  output logic irq_o,
  output logic wake_o,
  output logic [3:0] external_interrupt_lines_o,
  output logic cal_out_o
);

  // Alarm comparison of one alarm word against the calendar
  function automatic logic alm_match(input logic [31:0] a, input logic [31:0] s,
                                     input logic [31:0] t, input logic [31:0] d,
                                     input logic [12:0] ss);
    logic day_ok;
    day_ok = a[30] ? (a[26:24] == d[15:13]) : (a[29:24] == d[5:0]);
    return (a[31] | day_ok) & (a[23] | (a[22:16] == t[22:16])) &
           (a[15] | (a[14:8] == t[14:8])) & (a[7] | (a[6:0] == t[6:0])) &
           (~s[31] | (s[12:0] == ss));
  endfunction : alm_match

  // BCD increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : (v + 8'h01);
    return r;
  endfunction : bcd_inc

  // Pin synchronisers and edge detect
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_s3;
  wire logic [6:0] pin_rise = pin_s2 & ~pin_s3;
  wire logic battery_s = pin_s2[6];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pin_s1 <= 7'h00;
      pin_s2 <= 7'h00;
      pin_s3 <= 7'h00;
    end else begin
      pin_s1 <= {battery_mode_i, tstamp_i, tamper_i, ref_clk_i, hse_clk_i, lsi_clk_i, lse_clk_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Software registers
  logic [`RBC_CTRL_W-1:0] ctrl;
  logic [6:0] presc_a;
  logic [12:0] presc_s;
  logic [15:0] wake_reload;
  logic [31:0] alm_a;
  logic [31:0] alm_b;
  logic [31:0] alm_a_ss;
  logic [31:0] alm_b_ss;
  logic [`RBC_STAT_W-1:0] status;
  logic [`RBC_STAT_W-1:0] irq_mask;
  logic [31:0] ts_time;

  // Calendar state
  logic [6:0] sec;
  logic [6:0] min;
  logic [5:0] hr;
  logic pm;
  logic [2:0] wday;
  logic [5:0] date;
  logic [4:0] month;
  logic [7:0] year;

  // Address decode
  wire logic we_time = reg_wr_i & (reg_addr_i == `RBC_A_TIME);
  wire logic we_date = reg_wr_i & (reg_addr_i == `RBC_A_DATE);
  wire logic we_ctrl = reg_wr_i & (reg_addr_i == `RBC_A_CTRL);
  wire logic we_presc = reg_wr_i & (reg_addr_i == `RBC_A_PRESC);
  wire logic we_wake = reg_wr_i & (reg_addr_i == `RBC_A_WAKE);
  wire logic we_alm_a = reg_wr_i & (reg_addr_i == `RBC_A_ALM_A);
  wire logic we_alm_b = reg_wr_i & (reg_addr_i == `RBC_A_ALM_B);
  wire logic we_alm_a_ss = reg_wr_i & (reg_addr_i == `RBC_A_ALM_A_SS);
  wire logic we_alm_b_ss = reg_wr_i & (reg_addr_i == `RBC_A_ALM_B_SS);
  wire logic we_status = reg_wr_i & (reg_addr_i == `RBC_A_STATUS);
  wire logic we_mask = reg_wr_i & (reg_addr_i == `RBC_A_MASK);
  wire logic [7:0] bkp_off = reg_addr_i - `RBC_A_BKP_BASE;
  wire logic [4:0] bkp_idx = bkp_off[6:2];
  wire logic bkp_hit = (reg_addr_i >= `RBC_A_BKP_BASE) & (reg_addr_i < `RBC_A_BKP_END) &
                       (reg_addr_i[1:0] == 2'h0);

  // Control fields
  wire logic fmt12 = ctrl[`RBC_C_FMT12];
  wire logic [2:0] wake_sel = ctrl[`RBC_C_WSEL_HI:`RBC_C_WSEL_LO];
  wire rbc_pkg::rbc_clk_src_e clk_src =
    rbc_pkg::rbc_clk_src_e'(ctrl[`RBC_C_SRC_HI:`RBC_C_SRC_LO]);

  logic [6:0] hse_div;
  wire logic hse_tick = pin_rise[2] & (hse_div == `RBC_HSE_DIV_TC);

  wire logic rtc_tick = (clk_src == rbc_pkg::RBC_SRC_LSE) ? pin_rise[0] :
                        (clk_src == rbc_pkg::RBC_SRC_LSI) ? pin_rise[1] :
                        (clk_src == rbc_pkg::RBC_SRC_HSE) ? hse_tick : 1'b0;

  logic [6:0] apre;
  logic [12:0] subsec;
  wire logic apre_tick = rtc_tick & (apre == 7'h00);
  wire logic spre_tick = apre_tick & (subsec == 13'h0000);
  wire logic presc_load = we_time | we_presc;

  // mains reference counted to one second
  logic [5:0] ref_cnt;
  wire logic [5:0] ref_tc = ctrl[`RBC_C_REF_60] ? `RBC_REF60_TC : `RBC_REF50_TC;
  wire logic ref_tick = pin_rise[3] & (ref_cnt == ref_tc);
  wire logic sec_tick = ctrl[`RBC_C_REF_EN] ? ref_tick : spre_tick;

  // last day of the month with leap years
  wire logic leap = year[4] ? ((year[3:0] == 4'h2) | (year[3:0] == 4'h6)) :
                    ((year[3:0] == 4'h0) | (year[3:0] == 4'h4) | (year[3:0] == 4'h8));
  wire logic m30 = (month == 5'h04) | (month == 5'h06) | (month == 5'h09) | (month == 5'h11);
  wire logic [5:0] last_day = (month == 5'h02) ? (leap ? 6'h29 : 6'h28) :
                              m30 ? 6'h30 : 6'h31;

  wire logic hr_day = fmt12 ? ((hr == 6'h11) & pm) : (hr == 6'h23);
  wire logic wrap_s = sec_tick & (sec == 7'h59);
  wire logic wrap_m = wrap_s & (min == 7'h59);
  wire logic wrap_h = wrap_m & hr_day;
  wire logic wrap_d = wrap_h & (date == last_day);
  wire logic wrap_mo = wrap_d & (month == 5'h12);

  wire logic [7:0] sec_inc = bcd_inc({1'b0, sec});
  wire logic [7:0] min_inc = bcd_inc({1'b0, min});
  wire logic [7:0] hr_inc = bcd_inc({2'h0, hr});
  wire logic [7:0] date_inc = bcd_inc({2'h0, date});
  wire logic [7:0] month_inc = bcd_inc({3'h0, month});
  wire logic [7:0] year_inc = bcd_inc(year);
  wire logic [5:0] hr_step = fmt12 ? ((hr == 6'h12) ? 6'h01 : hr_inc[5:0]) :
                             ((hr == 6'h23) ? 6'h00 : hr_inc[5:0]);

  // Next calendar values, software write first
  wire logic [6:0] next_sec = we_time ? reg_wdata_i[6:0] :
                              !sec_tick ? sec : (sec == 7'h59) ? 7'h00 : sec_inc[6:0];
  wire logic [6:0] next_min = we_time ? reg_wdata_i[14:8] :
                              !wrap_s ? min : (min == 7'h59) ? 7'h00 : min_inc[6:0];
  wire logic [5:0] next_hr = we_time ? reg_wdata_i[21:16] : wrap_m ? hr_step : hr;
  // meridian flips at eleven to twelve
  wire logic next_pm = we_time ? reg_wdata_i[22] :
                       (wrap_m & fmt12 & (hr == 6'h11)) ? ~pm : pm;
  wire logic [2:0] next_wday = we_date ? reg_wdata_i[15:13] :
                               !wrap_h ? wday : (wday == 3'h7) ? 3'h1 : wday + 3'h1;
  wire logic [5:0] next_date = we_date ? reg_wdata_i[5:0] :
                               !wrap_h ? date : (date == last_day) ? 6'h01 : date_inc[5:0];
  wire logic [4:0] next_month = we_date ? reg_wdata_i[12:8] :
                                !wrap_d ? month : (month == 5'h12) ? 5'h01 : month_inc[4:0];
  wire logic [7:0] next_year = we_date ? reg_wdata_i[23:16] :
                               !wrap_mo ? year : (year == 8'h99) ? 8'h00 : year_inc;

  // Packed calendar words
  wire logic [31:0] time_w = {9'h000, pm, hr, 1'b0, min, 1'b0, sec};
  wire logic [31:0] date_w = {8'h00, year, wday, month, 2'h0, date};

  wire logic match_a = ctrl[`RBC_C_ALM_A_EN] & alm_match(alm_a, alm_a_ss, time_w, date_w, subsec);
  wire logic match_b = ctrl[`RBC_C_ALM_B_EN] & alm_match(alm_b, alm_b_ss, time_w, date_w, subsec);
  logic match_a_q;
  logic match_b_q;

  logic [3:0] wdiv;
  logic [16:0] wake_cnt;
  wire logic [3:0] wdiv_mask = 4'hf >> wake_sel[1:0];
  wire logic wake_ck = wake_sel[2] ? sec_tick : (rtc_tick & ((wdiv & wdiv_mask) == wdiv_mask));
  wire logic [16:0] wake_load = {wake_sel[2] & wake_sel[1], wake_reload};
  wire logic wake_en = ctrl[`RBC_C_WAKE_EN];
  wire logic wake_hit = wake_en & wake_ck & (wake_cnt == 17'h00000);

  // Event collection, set wins over write-one clear
  wire logic [`RBC_STAT_W-1:0] stat_set = {pin_rise[5], pin_rise[4], wake_hit,
                                           match_b & ~match_b_q, match_a & ~match_a_q};
  wire logic [`RBC_STAT_W-1:0] stat_clr = we_status ? reg_wdata_i[`RBC_STAT_W-1:0] :
                                                      {`RBC_STAT_W{1'b0}};
  wire logic [`RBC_STAT_W-1:0] next_status = (status & ~stat_clr) | stat_set;

  logic [5:0] cal_div;

  // Calendar and prescaler state
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sec <= 7'h00;
      min <= 7'h00;
      hr <= 6'h00;
      pm <= 1'b0;
      wday <= 3'(`RBC_DATE_RST >> 13);
      date <= 6'(`RBC_DATE_RST);
      month <= 5'(`RBC_DATE_RST >> 8);
      year <= 8'(`RBC_DATE_RST >> 16);
    end else begin
      sec <= next_sec;
      min <= next_min;
      hr <= next_hr;
      pm <= next_pm;
      wday <= next_wday;
      date <= next_date;
      month <= next_month;
      year <= next_year;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      apre <= `RBC_PRESC_A_RST;
      subsec <= `RBC_PRESC_S_RST;
    end else if (presc_load) begin
      apre <= we_presc ? reg_wdata_i[22:16] : presc_a;
      subsec <= we_presc ? reg_wdata_i[12:0] : presc_s;
    end else if (rtc_tick) begin
      apre <= (apre == 7'h00) ? presc_a : apre - 7'h01;
      if (apre_tick) begin
        subsec <= (subsec == 13'h0000) ? presc_s : subsec - 13'h0001;
      end
    end
  end

  // Source dividers and reference counter
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hse_div <= 7'h00;
      ref_cnt <= 6'h00;
      wdiv <= 4'h0;
      cal_div <= 6'h00;
    end else begin
      hse_div <= pin_rise[2] ? hse_div + 7'h01 : hse_div;
      ref_cnt <= !pin_rise[3] ? ref_cnt : ref_tick ? 6'h00 : ref_cnt + 6'h01;
      wdiv <= rtc_tick ? wdiv + 4'h1 : wdiv;
      cal_div <= rtc_tick ? cal_div + 6'h01 : cal_div;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_cnt <= {1'b0, `RBC_WAKE_RST};
    end else if (!wake_en) begin
      wake_cnt <= wake_load;
    end else if (wake_ck) begin
      wake_cnt <= (wake_cnt == 17'h00000) ? wake_load : wake_cnt - 17'h00001;
    end
  end

  // Control and configuration registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl <= `RBC_CTRL_RST;
      presc_a <= `RBC_PRESC_A_RST;
      presc_s <= `RBC_PRESC_S_RST;
      wake_reload <= `RBC_WAKE_RST;
      irq_mask <= {`RBC_STAT_W{1'b0}};
    end else begin
      ctrl <= we_ctrl ? reg_wdata_i[`RBC_CTRL_W-1:0] : ctrl;
      presc_a <= we_presc ? reg_wdata_i[22:16] : presc_a;
      presc_s <= we_presc ? reg_wdata_i[12:0] : presc_s;
      wake_reload <= we_wake ? reg_wdata_i[15:0] : wake_reload;
      irq_mask <= we_mask ? reg_wdata_i[`RBC_STAT_W-1:0] : irq_mask;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      alm_a <= 32'h0;
      alm_b <= 32'h0;
      alm_a_ss <= 32'h0;
      alm_b_ss <= 32'h0;
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end else begin
      alm_a <= we_alm_a ? reg_wdata_i : alm_a;
      alm_b <= we_alm_b ? reg_wdata_i : alm_b;
      alm_a_ss <= we_alm_a_ss ? reg_wdata_i : alm_a_ss;
      alm_b_ss <= we_alm_b_ss ? reg_wdata_i : alm_b_ss;
      match_a_q <= match_a;
      match_b_q <= match_b;
    end
  end

  // Status flags and timestamp capture
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status <= {`RBC_STAT_W{1'b0}};
      ts_time <= 32'h0;
    end else begin
      status <= next_status;
      ts_time <= pin_rise[5] ? time_w : ts_time;
    end
  end

  // Outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
      external_interrupt_lines_o <= 4'h0;
      cal_out_o <= 1'b0;
    end else begin
      irq_o <= |(status & irq_mask);
      wake_o <= |(status & irq_mask) & ~battery_s;
      external_interrupt_lines_o <= {stat_set[4], stat_set[3], stat_set[2],
                                     stat_set[1] | stat_set[0]};
      cal_out_o <= ctrl[`RBC_C_CAL_EN] & cal_div[5];
    end
  end

  // Register read selection
  wire logic [31:0] rd_val =
    (reg_addr_i == `RBC_A_TIME) ? time_w :
    (reg_addr_i == `RBC_A_DATE) ? date_w :
    (reg_addr_i == `RBC_A_CTRL) ? {19'h0, ctrl} :
    (reg_addr_i == `RBC_A_PRESC) ? {9'h0, presc_a, 3'h0, presc_s} :
    (reg_addr_i == `RBC_A_WAKE) ? {16'h0, wake_reload} :
    (reg_addr_i == `RBC_A_ALM_A) ? alm_a :
    (reg_addr_i == `RBC_A_ALM_B) ? alm_b :
    (reg_addr_i == `RBC_A_ALM_A_SS) ? alm_a_ss :
    (reg_addr_i == `RBC_A_ALM_B_SS) ? alm_b_ss :
    (reg_addr_i == `RBC_A_SUBSEC) ? {19'h0, subsec} :
    (reg_addr_i == `RBC_A_STATUS) ? {27'h0, status} :
    (reg_addr_i == `RBC_A_MASK) ? {27'h0, irq_mask} :
    (reg_addr_i == `RBC_A_TSTAMP) ? ts_time : 32'h0;

  // retained backup words and read register
  rbc_backup_mem u_bkp (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .wr_en_i(reg_wr_i & bkp_hit),
    .wr_idx_i(bkp_idx),
    .wr_data_i(reg_wdata_i),
    .rd_en_i(reg_rd_i),
    .rd_sel_i(bkp_hit),
    .rd_idx_i(bkp_idx),
    .bypass_i(rd_val),
    .rd_data_o(reg_rdata_o)
  );

endmodule : rbc_top

//--- rbc_top_monitor.sv
`include "rbc_cfg.svh"

module rbc_top_monitor (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic battery_mode_i,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic [3:0] external_interrupt_lines_o,
  input wire logic cal_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  wire logic bad_addr;
  wire logic mask_zero;
  // Unmapped offsets and a software write of an empty mask
  assign bad_addr = (reg_addr_i[1:0] != 2'h0) || (reg_addr_i >= `RBC_A_BKP_END) ||
                    (reg_addr_i > `RBC_A_TSTAMP && reg_addr_i < `RBC_A_BKP_BASE);
  assign mask_zero = reg_wr_i && reg_addr_i == `RBC_A_MASK && reg_wdata_i[4:0] == 5'h00;

  // Bus answers only after a read strobe
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data without a read");
  chk_unmapped_read: assert property (reg_rd_i && bad_addr |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  // Exit request, battery and interrupt relation
  chk_wake_battery: assert property (battery_mode_i [*5] |-> !wake_o)
    else $error("wake request on battery");
  chk_wake_irq: assert property (wake_o |-> irq_o)
    else $error("wake request without interrupt");
  // Off battery the exit request follows the interrupt
  chk_wake_follow: assert property ((!battery_mode_i) [*4] ##0 irq_o |-> wake_o)
    else $error("no wake request off battery");
  chk_line_pulse: assert property ((external_interrupt_lines_o &
    $past(external_interrupt_lines_o)) == 4'h0)
    else $error("event line longer than one cycle");
  chk_mask_clear: assert property (mask_zero |-> ##3 !irq_o && !wake_o)
    else $error("interrupt with empty mask");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !irq_o && !wake_o &&
    !cal_out_o && external_interrupt_lines_o == 4'h0 && reg_rdata_o == 32'h0)
    else $error("outputs active after reset");
  chk_cal_steady: assert property ($changed(cal_out_o) |=> $stable(cal_out_o) [*8])
    else $error("calibration output too fast");
endmodule : rbc_top_monitor

bind rbc_top rbc_top_monitor u_mon (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .battery_mode_i, .irq_o, .wake_o,
  .external_interrupt_lines_o, .cal_out_o);

//--- rbc_top_tb.sv
`include "rbc_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module rbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic lse_clk_i = 1'b0;
  logic lsi_clk_i = 1'b0;
  logic hse_clk_i = 1'b0;
  logic ref_clk_i = 1'b0;
  logic tamper_i = 1'b0;
  logic tstamp_i = 1'b0;
  logic battery_mode_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o, wake_o, cal_out_o;
  logic [3:0] external_interrupt_lines_o;
  logic [3:0] seen = 4'h0;
  logic [7:0] cyc = 8'h00;
  logic [31:0] v;
  int miscompares = 0;
  int checks_done = 0;
  int n, i;
  // Rollover cases: time, date, expected time, expected date
  logic [31:0] tm [6] = '{32'h235959, 32'h235959, 32'h235959, 32'h235959, 32'h115959,
    32'h515959};
  logic [31:0] dt [6] = '{32'h1e228, 32'h42228, 32'h44430, 32'h997231, 32'h12101, 32'h12101};
  logic [31:0] et [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h520000, 32'h120000};
  logic [31:0] ed [6] = '{32'h12301, 32'h44229, 32'h46501, 32'h8101, 32'h12101, 32'h14102};
  logic [31:0] src [4] = '{32'h100, 32'h200, 32'h310, 32'h330};

  rbc_top dut (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .lse_clk_i, .lsi_clk_i, .hse_clk_i, .ref_clk_i, .tamper_i, .tstamp_i,
    .battery_mode_i, .irq_o, .wake_o, .external_interrupt_lines_o, .cal_out_o);

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  // Slow clocks from one divider, event lines seen
  always @(posedge core_clk_i) begin
    cyc <= cyc + 8'h01;
    lse_clk_i <= cyc[2];
    lsi_clk_i <= cyc[3];
    hse_clk_i <= cyc[1];
    ref_clk_i <= cyc[1];
    seen <= seen | external_interrupt_lines_o;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask : rchk

  // Poll the time word until it moves
  task automatic tick(input logic [31:0] t0);
    v = t0;
    for (int k = 0; k < 3000 && v === t0; k++) rd(`RBC_A_TIME);
  endtask : tick

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #3600000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rchk(`RBC_A_PRESC, 32'h007f00ff);
    rchk(`RBC_A_TIME, 32'h0);
    rchk(`RBC_A_DATE, 32'h00002101);
    rchk(`RBC_A_WAKE, 32'h0000ffff);
    rchk(`RBC_A_CTRL, 32'h0);
    rchk(`RBC_A_STATUS, 32'h0);
    rchk(`RBC_A_MASK, 32'h0);
    wr(8'h34, 32'hffffffff);
    rchk(8'h34, 32'h0);
    rchk(8'h42, 32'h0);
    for (i = 0; i < `RBC_BKP_WORDS; i++) wr(`RBC_A_BKP_BASE + 8'(4 * i), 32'ha5c30000 + 32'(i));
    wr(`RBC_A_BKP_END, 32'h1);
    rchk(`RBC_A_BKP_END, 32'h0);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (i = 0; i < `RBC_BKP_WORDS; i++) rchk(`RBC_A_BKP_BASE + 8'(4 * i), 32'ha5c30000 + 32'(i));
    // Short second: two ticks
    wr(`RBC_A_PRESC, 32'h00000001);
    rd(`RBC_A_SUBSEC);
    `CHK(v <= 32'h1, 1'b1)
    // month ends, leap years, 12 hour
    for (i = 0; i < 6; i++) begin
      wr(`RBC_A_CTRL, {31'h0, i > 3});
      wr(`RBC_A_TIME, tm[i]);
      wr(`RBC_A_DATE, dt[i]);
      tick(tm[i]);
      `CHK(v, et[i])
      rchk(`RBC_A_DATE, ed[i]);
    end
    for (i = 0; i < 4; i++) begin
      wr(`RBC_A_CTRL, src[i]);
      wr(`RBC_A_TIME, 32'h0);
      tick(32'h0);
      `CHK(v, 32'h1)
    end
    wr(`RBC_A_CTRL, 32'h300);
    wr(`RBC_A_TIME, 32'h0);
    repeat (300) @(posedge core_clk_i);
    rchk(`RBC_A_TIME, 32'h0);
    for (i = 0; i < 2; i++) begin
      wr(`RBC_A_CTRL, 32'h2 << i);
      wr(`RBC_A_ALM_A + 8'(4 * i), 32'h80808005);
      wr(`RBC_A_MASK, 32'h1 << i);
      wr(`RBC_A_TIME, 32'h3);
      for (n = 0; n < 200 && irq_o !== 1'b1; n++) @(posedge core_clk_i);
      `CHK(wake_o, 1'b1)
      rchk(`RBC_A_STATUS, 32'h1 << i);
      rchk(`RBC_A_TIME, 32'h5);
      @(posedge core_clk_i);
      battery_mode_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      `CHK(wake_o, 1'b0)
      `CHK(irq_o, 1'b1)
      battery_mode_i <= 1'b0;
      wr(`RBC_A_STATUS, 32'h1f);
      repeat (3) @(posedge core_clk_i);
      `CHK(irq_o, 1'b0)
    end
    // wakeup period of reload plus one
    wr(`RBC_A_CTRL, 32'h0);
    wr(`RBC_A_WAKE, 32'h3);
    wr(`RBC_A_CTRL, 32'h8);
    repeat (300) @(posedge core_clk_i);
    rchk(`RBC_A_STATUS, 32'h0);
    repeat (400) @(posedge core_clk_i);
    rchk(`RBC_A_STATUS, 32'h4);
    `CHK(irq_o, 1'b0)
    // pin events, time captured, masked then unmasked
    wr(`RBC_A_TIME, 32'h00121314);
    tamper_i <= 1'b1;
    tstamp_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    tamper_i <= 1'b0;
    tstamp_i <= 1'b0;
    rchk(`RBC_A_TSTAMP, 32'h00121314);
    rchk(`RBC_A_STATUS, 32'h1c);
    wr(`RBC_A_MASK, 32'h18);
    repeat (3) @(posedge core_clk_i);
    `CHK(wake_o, 1'b1)
    wr(`RBC_A_MASK, 32'h0);
    wr(`RBC_A_CTRL, 32'h40);
    n = 0;
    v[0] = cal_out_o;
    repeat (1024) begin
      @(posedge core_clk_i);
      #1 if (cal_out_o !== v[0]) n++;
      v[0] = cal_out_o;
    end
    `CHK(n inside {[3:5]}, 1'b1)
    `CHK(seen, 4'hf)
    give_verdict();
  end
endmodule : rbc_top_tb
